//--- inc/timebase_map.svh
`ifndef TIMEBASE_MAP_SVH
`define TIMEBASE_MAP_SVH

`define TB_WIDTH          16

`define OFF_CONFIG        9'h000
`define OFF_CONFIG_SECOND 9'h004
`define OFF_TIME_ONE      9'h008
`define OFF_TIME_TWO      9'h00c

`define CFG_FAST          0
`define CFG_P1_LSB        1
`define CFG_GATE          3
`define CFG_EDGE          4
`define CFG_P2_LSB        5
`define CFG_STOP          7
`define RD_STOPPED        8
`define SEC_HALF          0

`define CFG_RESET         8'h00
`define SEC_RESET         1'b0

`define DIV_HALF          6'h02
`define DIV_FAST          6'h04
`define DIV_SLOW          6'h20
`define EIGHTH_LAST       3'h7
`define FILTER_LAST       2'h1

`endif

//--- inc/timebase_pkg.sv
`include "timebase_map.svh"

package timebase_pkg;

    typedef struct packed {
        logic [7:0]           cfg;
        logic                 half;
        logic                 stopped;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
        logic [`TB_WIDTH-1:0] tb_one;
        logic [`TB_WIDTH-1:0] tb_two;
    } top_state_type;

    typedef struct packed {
        logic [5:0] base_cnt;
        logic [2:0] pre_cnt;
        logic       tick;
    } one_state_type;

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic [1:0] flt_cnt;
        logic       filt;
        logic [2:0] eighth_cnt;
        logic [2:0] pre_cnt;
        logic       tick;
    } two_state_type;

endpackage

//--- inc/timebase_ctrl_if.sv
`timescale 1ns/1ps

interface timebase_ctrl_if;
    logic       run;
    logic       half_rate_select;
    logic       fast_base_select;
    logic [1:0] base_one_prescale_field;
    logic       base_two_gate_select;
    logic       base_two_edge_select;
    logic [1:0] base_two_prescale_field;
    logic       tick_one;
    logic       tick_two;

    modport one (
        input  run,
        input  half_rate_select,
        input  fast_base_select,
        input  base_one_prescale_field,
        output tick_one
    );

    modport two (
        input  run,
        input  base_two_gate_select,
        input  base_two_edge_select,
        input  base_two_prescale_field,
        output tick_two
    );
endinterface

//--- rtl/base_one_source.sv
`timescale 1ns/1ps
`include "timebase_map.svh"

module base_one_source (
    input wire logic  pclk,
    input wire logic  presetn,
    timebase_ctrl_if.one ctl
);
    timebase_pkg::one_state_type state;
    timebase_pkg::one_state_type next_state;
    logic [5:0] base_div;
    logic       base_tick;
    logic [2:0] pre_last;

    assign ctl.tick_one = state.tick;

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        base_div = ctl.half_rate_select ? `DIV_HALF :
                   (ctl.fast_base_select ? `DIV_FAST : `DIV_SLOW);
        base_tick = (state.base_cnt >= base_div - 6'h01);
        pre_last = 3'((4'h1 << ctl.base_one_prescale_field) - 4'h1);
        if (ctl.run) begin
            next_state.base_cnt = base_tick ? 6'h00 : state.base_cnt + 6'h01;
            if (ctl.half_rate_select) begin
                // prescaler bypassed at half rate
                next_state.tick = base_tick;
                next_state.pre_cnt = 3'h0;
            end else if (base_tick) begin
                // fast base with field 00 gives a tick every 4 clocks
                if (state.pre_cnt >= pre_last) begin
                    next_state.tick = 1'b1;
                    next_state.pre_cnt = 3'h0;
                end else begin
                    next_state.pre_cnt = state.pre_cnt + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        state.tick |=> !state.tick)
        else $error("time base one ticks back to back");

    a_half_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (state.tick && ctl.half_rate_select && ctl.run)
        ##1 (ctl.half_rate_select && ctl.run) |=> state.tick)
        else $error("half rate tick not every two clocks");

    a_slow_gap: assert property (@(posedge pclk) disable iff (!presetn)
        state.tick && ctl.run && !ctl.half_rate_select && !ctl.fast_base_select
        |=> (!state.tick || ctl.half_rate_select || ctl.fast_base_select)[*8])
        else $error("slow base tick too early");
endmodule

//--- rtl/base_two_source.sv
`timescale 1ns/1ps
`include "timebase_map.svh"

module base_two_source (
    input wire logic  pclk,
    input wire logic  presetn,
    input wire logic  base_two_external_pin,
    timebase_ctrl_if.two ctl
);
    timebase_pkg::two_state_type state;
    timebase_pkg::two_state_type next_state;
    logic       filt_flip;
    logic       rise;
    logic       fall;
    logic       eighth_pulse;
    logic       src_pulse;
    logic [2:0] pre_last;

    assign ctl.tick_two = state.tick;

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        next_state.sync1 = base_two_external_pin;
        next_state.sync2 = state.sync1;
        // a level must hold two clocks to pass; latency fits the nine-clock edge spacing
        filt_flip = (state.sync2 != state.filt) && (state.flt_cnt == `FILTER_LAST);
        rise = filt_flip && !state.filt;
        fall = filt_flip && state.filt;
        eighth_pulse = (state.eighth_cnt == `EIGHTH_LAST);
        pre_last = 3'((4'h1 << ctl.base_two_prescale_field) - 4'h1);
        case ({ctl.base_two_edge_select, ctl.base_two_gate_select})
            2'b00:   src_pulse = rise;
            2'b01:   src_pulse = eighth_pulse && state.sync2;
            2'b10:   src_pulse = fall;
            2'b11:   src_pulse = rise || fall;
            default: src_pulse = 1'b0;
        endcase
        if (ctl.run) begin
            next_state.eighth_cnt = state.eighth_cnt + 3'h1;
            if (state.sync2 == state.filt) begin
                next_state.flt_cnt = 2'h0;
            end else if (filt_flip) begin
                next_state.filt = state.sync2;
                next_state.flt_cnt = 2'h0;
            end else begin
                next_state.flt_cnt = state.flt_cnt + 2'h1;
            end
            if (src_pulse) begin
                if (state.pre_cnt >= pre_last) begin
                    next_state.tick = 1'b1;
                    next_state.pre_cnt = 3'h0;
                end else begin
                    next_state.pre_cnt = state.pre_cnt + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // gate select with edge select set means both pin edges, not the gated clock
    a_gate_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        ctl.base_two_gate_select && !ctl.base_two_edge_select && !state.sync2
        |=> !state.tick)
        else $error("gated clock counted while pin low");

    a_gate_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        state.tick && ctl.base_two_gate_select && !ctl.base_two_edge_select
        |=> (!state.tick || !ctl.base_two_gate_select || ctl.base_two_edge_select)[*7])
        else $error("gated time base two faster than clock by eight");

    a_edge_filtered: assert property (@(posedge pclk) disable iff (!presetn)
        ctl.run && !ctl.base_two_gate_select && src_pulse
        |-> state.sync2 != state.filt && $past(state.sync2) != state.filt)
        else $error("pin edge counted without filtering");
endmodule

//--- rtl/timebase_prescalers.sv
// Overview of operation
// - time base one input is system clock divided by 2, 4 or 32
// - half rate select set: time base one counts at clock over two
// - half rate clear: fast base 0 gives clock/32, fast base 1 clock/4
// - with half rate clear, time base one prescale field 00..11 divides by 1, 2, 4, 8
// - finest time base one resolution is two system clocks
// - edge/gate select: rise, gated clock, fall, both edges
// - gated mode counts clock/8 while pin high, blocked while low
// - pin edges are synchronized and filtered before counting
// - time base two prescale 1, 2, 4, 8 from configuration field
// - gated path gives clock/8, /16, /32, /64
// - 512-byte register space, unimplemented locations read zero
// - stop bit halts and freezes both time bases, sets stopped flag
`timescale 1ns/1ps
`include "timebase_map.svh"

module timebase_prescalers (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [8:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 base_two_external_pin,
    output logic      [`TB_WIDTH-1:0] time_base_one,
    output logic      [`TB_WIDTH-1:0] time_base_two,
    output logic                      stopped_flag
);
    timebase_pkg::top_state_type state;
    timebase_pkg::top_state_type next_state;
    timebase_ctrl_if             ctl ();
    logic                        setup;
    logic                        access;
    logic                        run;
    logic                        mapped;
    logic [31:0]                 read_word;

    assign run = !state.cfg[`CFG_STOP];
    assign ctl.run = run;
    assign ctl.half_rate_select = state.half;
    assign ctl.fast_base_select = state.cfg[`CFG_FAST];
    assign ctl.base_one_prescale_field = state.cfg[`CFG_P1_LSB +: 2];
    assign ctl.base_two_gate_select = state.cfg[`CFG_GATE];
    assign ctl.base_two_edge_select = state.cfg[`CFG_EDGE];
    assign ctl.base_two_prescale_field = state.cfg[`CFG_P2_LSB +: 2];

    base_one_source u_one (
        .pclk    (pclk),
        .presetn (presetn),
        .ctl     (ctl)
    );

    base_two_source u_two (
        .pclk                  (pclk),
        .presetn               (presetn),
        .base_two_external_pin (base_two_external_pin),
        .ctl                   (ctl)
    );

    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign time_base_one = state.tb_one;
    assign time_base_two = state.tb_two;
    assign stopped_flag = state.stopped;

    always_comb begin
        next_state = state;
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;
        setup = psel && !penable;
        access = psel && penable && state.pready;
        read_word = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `OFF_CONFIG: begin
                read_word[7:0] = state.cfg;
                read_word[`RD_STOPPED] = state.stopped;
            end
            `OFF_CONFIG_SECOND: read_word[`SEC_HALF] = state.half;
            `OFF_TIME_ONE:      read_word[`TB_WIDTH-1:0] = state.tb_one;
            `OFF_TIME_TWO:      read_word[`TB_WIDTH-1:0] = state.tb_two;
            default:            mapped = 1'b0;
        endcase
        if (setup) begin
            next_state.pready = 1'b1;
            next_state.prdata = read_word;
        end
        // every access is taken as a full word
        if (access && pwrite) begin
            case (paddr)
                `OFF_CONFIG:        next_state.cfg = pwdata[7:0];
                `OFF_CONFIG_SECOND: next_state.half = pwdata[`SEC_HALF];
                default:            next_state.half = state.half;
            endcase
        end
        next_state.stopped = state.cfg[`CFG_STOP];
        if (ctl.tick_one && run) begin
            next_state.tb_one = state.tb_one + 16'h0001;
        end
        if (ctl.tick_two && run) begin
            next_state.tb_two = state.tb_two + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
            state.cfg <= `CFG_RESET;
            state.half <= `SEC_RESET;
        end else begin
            state <= next_state;
        end
    end

    a_tb_one_step: assert property (@(posedge pclk) disable iff (!presetn)
        ctl.tick_one && run |=> state.tb_one == $past(state.tb_one) + 16'h0001)
        else $error("time base one did not step by one");

    a_tb_two_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl.tick_two |=> $stable(state.tb_two))
        else $error("time base two moved without a tick");

    a_stop_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        state.cfg[`CFG_STOP] |=> $stable(state.tb_one) && $stable(state.tb_two))
        else $error("time base moved while stopped");

    a_stop_flag: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state.cfg[`CFG_STOP]) |=> state.stopped ##1 1'b1)
        else $error("stopped flag not raised");

    a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && !mapped |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero");

    a_config_write: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && paddr == `OFF_CONFIG |=> state.cfg == $past(pwdata[7:0]))
        else $error("configuration write lost");
endmodule

//--- test/pin_source.sv
`timescale 1ns/1ps

module pin_source (
    input  wire logic       pclk,
    input  wire logic       run,
    input  wire logic       idle_level,
    input  wire logic [7:0] half_len,
    output logic            pin
);
    logic [7:0] cnt;

    initial begin
        pin = 1'b0;
        cnt = 8'h00;
    end

    // square wave while running, else a steady level; half_len kept at 9 or more
    always @(posedge pclk) begin
        if (!run) begin
            pin <= idle_level;
            cnt <= 8'h00;
        end else if (cnt >= half_len - 8'h01) begin
            pin <= ~pin;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

//--- test/timebase_prescalers_tb.sv
`timescale 1ns/1ps
`include "timebase_map.svh"

module timebase_prescalers_tb;
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [8:0]           paddr = 9'h000;
    logic [31:0]          pwdata = 32'h0000_0000;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 pin;
    logic                 pin_run = 1'b0;
    logic                 pin_idle = 1'b0;
    logic [`TB_WIDTH-1:0] time_base_one;
    logic [`TB_WIDTH-1:0] time_base_two;
    logic                 stopped_flag;
    int                   failures = 0;
    int                   samples_checked = 0;
    int                   cycles = 0;

    always #50 pclk = ~pclk;

    timebase_prescalers uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .base_two_external_pin(pin), .time_base_one(time_base_one),
        .time_base_two(time_base_two), .stopped_flag(stopped_flag));

    pin_source src (.pclk(pclk), .run(pin_run), .idle_level(pin_idle),
        .half_len(8'h0a), .pin(pin));

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // request held until pready is seen high at a rising edge; word accesses only
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        check("pslverr", {31'h0, pslverr}, 32'h0000_0000);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0000_0000, q);
        check("read", q, exp);
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    function automatic logic [15:0] cur(input bit two);
        return two ? time_base_two : time_base_one;
    endfunction

    task automatic wait_change(input bit two, output int n);
        logic [15:0] last;
        last = cur(two);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (cur(two) === last && n < 700);
        check("step", 32'(cur(two)), 32'(last + 16'h0001));
    endtask

    task automatic period(input bit two, input int exp);
        int n;
        wait_change(two, n);
        wait_change(two, n);
        wait_change(two, n);
        check("period", n, exp);
    endtask

    task automatic test_regs();
        rd_chk(`OFF_CONFIG, 32'h0000_0000);
        rd_chk(`OFF_CONFIG_SECOND, 32'h0000_0000);
        wr(9'h010, 32'hffff_ffff);
        rd_chk(9'h010, 32'h0000_0000);
        rd_chk(9'h1fc, 32'h0000_0000);
        rd_chk(9'h002, 32'h0000_0000);
        wr(`OFF_CONFIG, 32'h0000_0066);
        rd_chk(`OFF_CONFIG, 32'h0000_0066);
        wr(`OFF_CONFIG, 32'h0000_0000);
        $display("test regs done");
    endtask

    task automatic test_one();
        for (int f = 0; f < 2; f++) begin
            for (int p = 0; p < 4; p++) begin
                wr(`OFF_CONFIG, 32'(f + (p << `CFG_P1_LSB)));
                period(0, (f == 1 ? 4 : 32) << p);
            end
        end
        wr(`OFF_CONFIG_SECOND, 32'h0000_0001);
        period(0, 2);
        $display("test time base one done");
    endtask

    task automatic test_two();
        logic [15:0] hold;
        pin_idle <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            wr(`OFF_CONFIG, 32'((1 << `CFG_GATE) + (p << `CFG_P2_LSB)));
            period(1, 8 << p);
        end
        pin_idle <= 1'b0;
        repeat (10) @(negedge pclk);
        hold = time_base_two;
        repeat (200) @(negedge pclk);
        check("gated low", 32'(time_base_two), 32'(hold));
        rd_chk(`OFF_TIME_TWO, 32'(hold));
        pin_run <= 1'b1;
        wr(`OFF_CONFIG, 32'h0000_0000);
        period(1, 20);
        wr(`OFF_CONFIG, 32'(1 << `CFG_EDGE));
        period(1, 20);
        wr(`OFF_CONFIG, 32'((1 << `CFG_EDGE) + (1 << `CFG_GATE)));
        period(1, 10);
        wr(`OFF_CONFIG, 32'(1 << `CFG_P2_LSB));
        period(1, 40);
        pin_run <= 1'b0;
        $display("test time base two done");
    endtask

    task automatic test_stop();
        logic [15:0] hold;
        wr(`OFF_CONFIG, 32'(1 << `CFG_STOP));
        repeat (3) @(negedge pclk);
        check("stopped", {31'h0, stopped_flag}, 32'h0000_0001);
        hold = time_base_one;
        repeat (50) @(negedge pclk);
        check("frozen", 32'(time_base_one), 32'(hold));
        rd_chk(`OFF_CONFIG, 32'h0000_0180);
        rd_chk(`OFF_TIME_ONE, 32'(hold));
        wr(`OFF_CONFIG, 32'h0000_0000);
        period(0, 2);
        check("running", {31'h0, stopped_flag}, 32'h0000_0000);
        $display("test stop done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_one();
        test_stop();
        test_two();
        test_done();
    end
endmodule
